/* File: src/sc_b_switch_control.sv */
/*
 * Switch-phase control for four switched-capacitor type B cells.
 * Holds control registers 1, 2 and 3 of each cell and turns them, with the
 * two non-overlapping phase clocks, into switch enables for the analog cells.
 * Assumes phase clocks, sample window and comparator outputs come from outside
 * the clk domain (they are synchronised here) and that phase one and phase two
 * never overlap. The phase swap bit lives in control register 0 outside this block.
 */
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module sc_b_switch_control (
	input wire logic clk,
	input wire logic rst_n,
	input wire sc_b_pkg::reg_req_t req,
	output logic [7:0] rdata,
	input wire logic [3:0] phase_swap,
	input wire logic phase_one_clock,
	input wire logic phase_two_clock,
	input wire logic sample_window,
	input wire logic [3:0] cmp_raw,
	output sc_b_pkg::cell_switch_t [3:0] cell_sw,
	output logic [3:0] cmp_bus_out,
	output logic [3:0] cmp_bus_oe,
	output logic [1:0] column_cmp_bus
);
	import sc_b_pkg::*;

	// ------------------------------------------------------------
	// register access
	// ------------------------------------------------------------
	// maps a byte address to a store index, 4'hf when unmapped
	function automatic logic [3:0] addr_index(input logic [7:0] a);
		case (a)
			off_cell11_ctrl1: addr_index = 4'h0;
			off_cell11_ctrl2: addr_index = 4'h1;
			off_cell11_ctrl3: addr_index = 4'h2;
			off_cell13_ctrl1: addr_index = 4'h3;
			off_cell13_ctrl2: addr_index = 4'h4;
			off_cell13_ctrl3: addr_index = 4'h5;
			off_cell20_ctrl1: addr_index = 4'h6;
			off_cell20_ctrl2: addr_index = 4'h7;
			off_cell20_ctrl3: addr_index = 4'h8;
			off_cell22_ctrl1: addr_index = 4'h9;
			off_cell22_ctrl2: addr_index = 4'ha;
			off_cell22_ctrl3: addr_index = 4'hb;
			default: addr_index = 4'hf;
		endcase
	endfunction

	wire logic [3:0] reg_index = addr_index(req.addr);
	wire logic reg_hit = (reg_index != 4'hf);
	wire logic [reg_count*8-1:0] all_regs;
	logic [7:0] store_rdata;
	rd_state_t rd_state;

	// reserved A codes are still stored and read back unchanged
	sc_b_regfile u_regs (
		.clk(clk),
		.rst_n(rst_n),
		.wr_en(req.wr && reg_hit),
		.rd_en(req.rd && reg_hit),
		.index(reg_index),
		.wdata(req.wdata),
		.rdata(store_rdata),
		.all_regs(all_regs)
	);

	// marks the cycle after a read; other cycles read as zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_state <= rd_idle;
		end else begin
			rd_state <= req.rd ? rd_valid : rd_idle;
		end
	end

	assign rdata = (rd_state == rd_valid) ? store_rdata : 8'h00;

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	// three stages; a change counts when the second and third agree
	logic [6:0] sync1;
	logic [6:0] sync2;
	logic [6:0] sync3;
	logic [6:0] clean;
	wire logic [6:0] raw_in = {sample_window, phase_two_clock, phase_one_clock, cmp_raw};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 7'h00;
			sync2 <= 7'h00;
			sync3 <= 7'h00;
		end else begin
			sync1 <= raw_in;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// filtered copy moves only when stages two and three agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clean <= 7'h00;
		end else begin
			clean <= (sync2 & sync3) | (clean & (sync2 | sync3));
		end
	end

	wire logic [3:0] cmp_now = clean[3:0];
	wire logic ph1 = clean[4];
	wire logic ph2 = clean[5];
	wire logic late_ph2 = clean[6] & ph2;
	logic ph1_prev;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph1_prev <= 1'b0;
		end else begin
			ph1_prev <= ph1;
		end
	end

	wire logic ph1_rise = ph1 & ~ph1_prev;

	// ------------------------------------------------------------
	// comparator latch
	// ------------------------------------------------------------
	// caught at the rising edge of phase one, held through phase two
	logic [3:0] cmp_held;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_held <= 4'h0;
		end else if (ph1_rise) begin
			cmp_held <= cmp_now;
		end
	end

	// ------------------------------------------------------------
	// per-cell switch decode
	// ------------------------------------------------------------
	cell_switch_t [3:0] next_sw;

	genvar c;
	generate
		for (c = 0; c < cell_count; c++) begin : g_cell
			wire logic [7:0] r1 = all_regs[(c*regs_per_cell)*8 +: 8];
			wire logic [7:0] r2 = all_regs[(c*regs_per_cell+1)*8 +: 8];
			wire logic [7:0] r3 = all_regs[(c*regs_per_cell+2)*8 +: 8];
			wire logic [2:0] a_sel = r1[pos_a_sel +: 3];
			wire logic nulling = r2[pos_null];
			wire logic col_en = r2[pos_col_bus];
			wire logic [1:0] ref_sel = r3[pos_ref_sel +: 2];
			wire logic gated_bit = r3[pos_gated_fb];
			wire logic ground_bit = r3[pos_ground_fb];
			wire logic bsw_bit = r3[pos_b_sw];
			// reserved codes leave every source switch open
			wire logic [5:0] a_onehot = (a_sel <= a_src_max) ?
				(6'h01 << a_sel) : 6'h00;
			// follow mode uses the held comparator of this cell
			wire logic [1:0] ref_eff = (ref_sel == ref_follow) ?
				(cmp_held[c] ? ref_high : ref_low) : ref_sel;
			wire logic [2:0] ref_onehot = {ref_eff == ref_low, ref_eff == ref_high,
				ref_eff == ref_ground};

			// switches follow the synchronised phases
			always_comb begin
				next_sw[c] = '0;
				next_sw[c].a_src_onehot = a_onehot;
				next_sw[c].a_ref_onehot = ref_onehot;
				next_sw[c].b_cap_size = r1[4:0];
				next_sw[c].c_cap_size = r2[4:0];
				next_sw[c].b_src = r3[pos_b_sel];
				next_sw[c].null_short = nulling & ph1;
				next_sw[c].in_to_ground = nulling & ph1;
				next_sw[c].in_to_amp = ~nulling | ph2;
				next_sw[c].sum_pair = nulling;
				next_sw[c].gated_fb = gated_bit & (~nulling | ph2);
				next_sw[c].ground_fb = ground_bit & ph1;
				next_sw[c].b_ends_ground = bsw_bit & ph1;
				next_sw[c].b_ends_connect = ~bsw_bit | ph2;
				next_sw[c].power = r3[1:0];
				next_sw[c].amp_on = (r3[1:0] != power_off);
				// floats when disabled; late phase two or continuous otherwise
				next_sw[c].col_bus_oe = col_en & (phase_swap[c] | late_ph2);
				next_sw[c].cmp_bus_oe = r2[pos_cmp_bus];
			end
		end
	endgenerate

	// switch controls leave through flip-flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cell_sw <= '0;
		end else begin
			cell_sw <= next_sw;
		end
	end

	// ------------------------------------------------------------
	// comparator bus
	// ------------------------------------------------------------
	// cells 11 and 20 share column one, 13 and 22 column two
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_bus_out <= 4'h0;
		end else begin
			cmp_bus_out <= cmp_held;
		end
	end

	generate
		for (c = 0; c < cell_count; c++) begin : g_oe
			assign cmp_bus_oe[c] = cell_sw[c].cmp_bus_oe;
		end
	endgenerate

	// an undriven column resolves low; two drivers are a software fault
	assign column_cmp_bus[0] = |(cmp_bus_oe[2:0] & cmp_bus_out[2:0] & 3'h5);
	assign column_cmp_bus[1] = |(cmp_bus_oe & cmp_bus_out & 4'ha);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_ph1_rise;
		!ph1_prev && ph1;
	endsequence

	chk_cmp_hold_phase: assert property (@(posedge clk) disable iff (!rst_n)
		s_ph1_rise |=> (cmp_held == $past(cmp_now)))
		else $error("comparator not caught at phase one rise");
	chk_col_bus_float: assert property (@(posedge clk) disable iff (!rst_n)
		!cell_sw[0].col_bus_oe || $past(all_regs[8+pos_col_bus]))
		else $error("column bus driven while disabled");
	chk_col_bus_late: assert property (@(posedge clk) disable iff (!rst_n)
		(all_regs[8+pos_col_bus] && !phase_swap[0] && !late_ph2) |=> !cell_sw[0].col_bus_oe)
		else $error("column bus driven outside late phase two");
	chk_cmp_bus_gate: assert property (@(posedge clk) disable iff (!rst_n)
		$past(all_regs[8+pos_cmp_bus]) == cmp_bus_oe[0])
		else $error("comparator bus enable mismatch");
	chk_cmp_bus_low: assert property (@(posedge clk) disable iff (!rst_n)
		(cmp_bus_oe[0] == 1'b0 && cmp_bus_oe[2] == 1'b0) |-> !column_cmp_bus[0])
		else $error("undriven comparator bus not low");
	chk_null_short: assert property (@(posedge clk) disable iff (!rst_n)
		(all_regs[8+pos_null] && ph1) |=> (cell_sw[0].null_short && !cell_sw[0].in_to_amp))
		else $error("nulling short missing in phase one");
	chk_null_off: assert property (@(posedge clk) disable iff (!rst_n)
		!all_regs[8+pos_null] ##1 !all_regs[8+pos_null] |-> !cell_sw[0].null_short)
		else $error("shorting switch closed without nulling");
	chk_gated_fb: assert property (@(posedge clk) disable iff (!rst_n)
		!$past(all_regs[16+pos_gated_fb]) |-> !cell_sw[0].gated_fb)
		else $error("gated feedback closed while off");
	chk_ground_fb: assert property (@(posedge clk) disable iff (!rst_n)
		cell_sw[0].ground_fb |-> $past(ph1))
		else $error("ground feedback closed outside phase one");
	chk_reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
		($past(all_regs[7:6]) == 2'h3) |-> (cell_sw[0].a_src_onehot == 6'h00))
		else $error("reserved A code connected a source");

endmodule

`default_nettype wire

/* File: src/sc_b_pkg.sv */
/*
 * Shared definitions for the switched-capacitor type B switch control block:
 * register offsets, field positions, reset values, source codes and carriers.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sc_b_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] off_cell11_ctrl1 = 8'h85;
	localparam logic [7:0] off_cell11_ctrl2 = 8'h86;
	localparam logic [7:0] off_cell11_ctrl3 = 8'h87;
	localparam logic [7:0] off_cell13_ctrl1 = 8'h8d;
	localparam logic [7:0] off_cell13_ctrl2 = 8'h8e;
	localparam logic [7:0] off_cell13_ctrl3 = 8'h8f;
	localparam logic [7:0] off_cell20_ctrl1 = 8'h91;
	localparam logic [7:0] off_cell20_ctrl2 = 8'h92;
	localparam logic [7:0] off_cell20_ctrl3 = 8'h93;
	localparam logic [7:0] off_cell22_ctrl1 = 8'h99;
	localparam logic [7:0] off_cell22_ctrl2 = 8'h9a;
	localparam logic [7:0] off_cell22_ctrl3 = 8'h9b;
	localparam logic [7:0] reg_reset = 8'h00;
	localparam int cell_count = 4;
	localparam int regs_per_cell = 3;
	localparam int reg_count = 12;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int pos_a_sel = 5;
	localparam int pos_col_bus = 7;
	localparam int pos_cmp_bus = 6;
	localparam int pos_null = 5;
	localparam int pos_ref_sel = 6;
	localparam int pos_gated_fb = 5;
	localparam int pos_ground_fb = 4;
	localparam int pos_b_sw = 3;
	localparam int pos_b_sel = 2;

	// ------------------------------------------------------------
	// codes
	// ------------------------------------------------------------
	localparam logic [2:0] a_src_high_ref = 3'h4;
	localparam logic [2:0] a_src_max = 3'h5;
	localparam logic [1:0] ref_ground = 2'h0;
	localparam logic [1:0] ref_high = 2'h1;
	localparam logic [1:0] ref_low = 2'h2;
	localparam logic [1:0] ref_follow = 2'h3;
	localparam logic [1:0] power_off = 2'h0;

	// read-back path states
	typedef enum logic [0:0] {
		rd_idle = 1'b0,
		rd_valid = 1'b1
	} rd_state_t;

	// switch controls of one cell
	typedef struct packed {
		logic [5:0] a_src_onehot;   // one-hot A source, all zero when reserved
		logic [2:0] a_ref_onehot;   // ground, high, low
		logic [4:0] b_cap_size;
		logic [4:0] c_cap_size;
		logic b_src;
		logic null_short;
		logic in_to_ground;
		logic in_to_amp;
		logic sum_pair;
		logic gated_fb;
		logic ground_fb;
		logic b_ends_ground;
		logic b_ends_connect;
		logic [1:0] power;
		logic amp_on;
		logic col_bus_oe;
		logic cmp_bus_oe;
	} cell_switch_t;

	// register port
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

endpackage

/* File: src/sc_b_regfile.sv */
/*
 * Small register store for the four cells, three control words each.
 * Read data come out of a register one cycle after the read strobe.
 * Assumes the caller decodes the address into an index and a hit.
 */
`timescale 1ns/1ps
`default_nettype none

module sc_b_regfile (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [3:0] index,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	output logic [sc_b_pkg::reg_count*8-1:0] all_regs
);
	import sc_b_pkg::*;

	logic [7:0] mem [reg_count];

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < reg_count; i++) begin : g_word
			// each word clears at reset and takes a hit write
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					mem[i] <= reg_reset;
				end else if (wr_en && index == 4'(i)) begin
					mem[i] <= wdata;
				end
			end
			assign all_regs[i*8 +: 8] = mem[i];
		end
	endgenerate

	// registered read port; unmapped reads return zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else if (rd_en) begin
			rdata <= mem[index];
		end else begin
			rdata <= 8'h00;
		end
	end

endmodule

`default_nettype wire

/* File: bench/testbench.sv */
/*
 * Self-checking bench for the type B switch control block: register store,
 * field decoding, phase-gated switch enables, bus drives and comparator latch.
 * Assumes the block's phase inputs settle into its outputs within 8 clocks.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import sc_b_pkg::*;

	// ------------------------------------------------------------
	// signals and instance
	// ------------------------------------------------------------
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	reg_req_t req = '0;
	logic [7:0] rdata;
	logic [3:0] phase_swap = 4'h0;
	logic phase_one_clock = 1'b0;
	logic phase_two_clock = 1'b0;
	logic sample_window = 1'b0;
	logic [3:0] cmp_raw = 4'h0;
	cell_switch_t [3:0] cell_sw;
	logic [3:0] cmp_bus_out;
	logic [3:0] cmp_bus_oe;
	logic [1:0] column_cmp_bus;
	int mismatches = 0;
	int n_compared = 0;
	// offsets in cell order, three control words per cell
	localparam logic [7:0] offs [12] = '{off_cell11_ctrl1, off_cell11_ctrl2, off_cell11_ctrl3,
		off_cell13_ctrl1, off_cell13_ctrl2, off_cell13_ctrl3, off_cell20_ctrl1,
		off_cell20_ctrl2, off_cell20_ctrl3, off_cell22_ctrl1, off_cell22_ctrl2,
		off_cell22_ctrl3};

	always #5 clk = ~clk;

	sc_b_switch_control uut (
		.clk(clk),
		.rst_n(rst_n),
		.req(req),
		.rdata(rdata),
		.phase_swap(phase_swap),
		.phase_one_clock(phase_one_clock),
		.phase_two_clock(phase_two_clock),
		.sample_window(sample_window),
		.cmp_raw(cmp_raw),
		.cell_sw(cell_sw),
		.cmp_bus_out(cmp_bus_out),
		.cmp_bus_oe(cmp_bus_oe),
		.column_cmp_bus(column_cmp_bus)
	);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic conclude();
		if (mismatches == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe, so sample there
	task automatic rcheck(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		check("register", rdata, exp);
	endtask

	// phase inputs pass a synchroniser, so give them time to land
	task automatic settle();
		repeat (8) @(posedge clk);
		#1;
	endtask

	task automatic setph(input logic p1, input logic p2);
		@(posedge clk);
		phase_one_clock <= p1;
		phase_two_clock <= p2;
		settle();
	endtask

	// held value, its drive enable and the resolved bus of cell 11
	task automatic lcheck(input logic [2:0] exp);
		check("latch", {5'h0, cmp_bus_out[0], cmp_bus_oe[0], column_cmp_bus[0]}, {5'h0, exp});
	endtask

	// ------------------------------------------------------------
	// watchdog: the tests need under 600 cycles
	// ------------------------------------------------------------
	initial begin
		#200000;
		mismatches++;
		conclude();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		int c;
		logic n;
		logic g;
		logic f0;
		logic ph1;
		logic ph2;
		logic en;
		logic sw;
		logic [5:0] eoh;
		logic [2:0] eref;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		// reset values, then a pattern in every register, then unmapped places
		for (int i = 0; i < 12; i++) begin
			rcheck(offs[i], 8'h00);
		end
		for (int i = 0; i < 12; i++) begin
			wr(offs[i], 8'(i * 16 + 15 - i));
		end
		for (int i = 0; i < 12; i++) begin
			rcheck(offs[i], 8'(i * 16 + 15 - i));
		end
		wr(8'h84, 8'hff);
		rcheck(8'h84, 8'h00);
		rcheck(8'h88, 8'h00);
		// field decoding: every A code once, every reference code and power code twice
		for (int j = 0; j < 8; j++) begin
			c = j % 4;
			wr(offs[c * 3], {3'(j), 5'(j * 4 + 3)});
			wr(offs[c * 3 + 1], 8'(31 - j * 4));
			wr(offs[c * 3 + 2], {2'(j), 3'h0, 1'(j), 2'(j >> 1)});
			settle();
			eoh = (j < 6) ? 6'(1 << j) : 6'h00;
			eref = (j % 4 == 0) ? 3'h1 : ((j % 4 == 1) ? 3'h2 : 3'h4);
			check("a_src", {2'h0, cell_sw[c].a_src_onehot}, {2'h0, eoh});
			check("b_cap", {3'h0, cell_sw[c].b_cap_size}, 8'(j * 4 + 3));
			check("c_cap", {3'h0, cell_sw[c].c_cap_size}, 8'(31 - j * 4));
			check("ctrl3", {1'b0, cell_sw[c].a_ref_onehot, cell_sw[c].b_src, cell_sw[c].power,
				cell_sw[c].amp_on}, {1'b0, eref, 1'(j), 2'(j >> 1), (j >> 1) != 0});
			rcheck(offs[c * 3], {3'(j), 5'(j * 4 + 3)});
		end
		// switch gating against both phases for every mix of the nulling, gated and ground bits
		for (int v = 0; v < 8; v++) begin
			c = v % 4;
			n = v[0];
			g = v[1];
			f0 = v[2];
			wr(offs[c * 3 + 1], {2'b00, n, 5'h00});
			wr(offs[c * 3 + 2], {2'b00, g, f0, g, 3'h0});
			for (int p = 0; p < 2; p++) begin
				ph1 = (p == 0);
				ph2 = (p == 1);
				setph(ph1, ph2);
				check("switches", {1'b0, cell_sw[c].null_short, cell_sw[c].in_to_ground,
					cell_sw[c].in_to_amp, cell_sw[c].sum_pair, cell_sw[c].gated_fb,
					cell_sw[c].ground_fb, cell_sw[c].b_ends_ground}, {1'b0, n & ph1, n & ph1,
					!n | ph2, n, g & (!n | ph2), f0 & ph1, g & ph1});
				if (g) begin
					check("b_connect", {7'h0, cell_sw[c].b_ends_connect}, {7'h0, ph2});
				end
			end
		end
		setph(1'b0, 1'b0);
		// column and comparator bus drive of cell 13 against swap and window
		for (int k = 0; k < 8; k++) begin
			en = k[0];
			sw = k[2];
			wr(offs[4], {en, en, 6'h00});
			@(posedge clk);
			phase_swap <= {2'b00, k[1], 1'b0};
			sample_window <= sw;
			phase_two_clock <= sw;
			settle();
			check("bus_oe", {4'h0, cell_sw[1].col_bus_oe, cell_sw[1].cmp_bus_oe, cmp_bus_oe[1],
				column_cmp_bus[1]}, {4'h0, en & (k[1] | sw), en, en, 1'b0});
		end
		@(posedge clk);
		phase_swap <= 4'h0;
		sample_window <= 1'b0;
		phase_two_clock <= 1'b0;
		// comparator of cell 11: caught at phase one rise only, then held
		wr(offs[1], 8'h40);
		wr(offs[2], 8'hc0);
		setph(1'b0, 1'b0);
		@(posedge clk);
		cmp_raw <= 4'h1;
		settle();
		lcheck(3'h2);
		setph(1'b1, 1'b0);
		lcheck(3'h7);
		check("ref_follow", {5'h0, cell_sw[0].a_ref_onehot}, 8'h02);
		@(posedge clk);
		cmp_raw <= 4'h0;
		settle();
		lcheck(3'h7);
		setph(1'b0, 1'b1);
		lcheck(3'h7);
		setph(1'b1, 1'b0);
		lcheck(3'h2);
		check("ref_follow", {5'h0, cell_sw[0].a_ref_onehot}, 8'h04);
		// a held high value with the drive off must leave the bus low
		@(posedge clk);
		cmp_raw <= 4'h1;
		setph(1'b0, 1'b0);
		setph(1'b1, 1'b0);
		wr(offs[1], 8'h00);
		settle();
		lcheck(3'h4);
		conclude();
	end
endmodule

`default_nettype wire
